// *** design/gauge_pack_config.v ***
`timescale 1ns/1ps
`include "gauge_pack_defines.vh"

module gauge_pack_config (
	// apb
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// gauging state from the engine
	input  wire        charging,
	input  wire        discharging,
	input  wire        relaxing,
	input  wire [11:0] chem_id,
	input  wire [15:0] volt_raw,
	input  wire [15:0] sense_raw,
	input  wire [15:0] sense_zero,
	// decoded controls to the engine
	output reg         charge_depth_end_update_en,
	output reg         voltage_consistency_check_en,
	output reg         temperature_banded_charge_report,
	output reg         phosphate_relax_mode_en,
	output reg         depth_weighting_en,
	output reg         fast_convergence_en,
	output reg         health_display_en,
	output reg         charge_percent_no_rise,
	output reg         fast_filter_near_empty,
	output reg         sleep_fast_sampling_en,
	output reg         hold_zero_in_relax,
	output reg         relax_step_allow,
	output reg         relax_filtering_allow,
	output reg         charge_smoothing_en,
	output reg         divider_source_select,
	output reg         internal_divider_on,
	output reg  [15:0] stack_voltage_mv,
	output reg  [15:0] sense_resistor_voltage
);

	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	reg [7:0]  opt_a_ff;
	reg [7:0]  opt_b_ff;
	reg [7:0]  opt_c_ff;
	reg [15:0] divider_ff;
	reg [7:0]  cells_ff;
	reg [15:0] offset_ff;
	reg [16:0] offset_cnt_ff;
	reg        cal_busy_ff;
	reg [15:0] cal_target_ff;

	wire        wr_en = psel & penable & pwrite & pready;
	wire        setup = psel & ~penable;
	wire [31:0] volt_prod = volt_raw * divider_ff;
	wire [15:0] volt_scaled = volt_prod[31:16] != 16'h0000 ? 16'hFFFF : volt_prod[15:0]; // RULE17
	// period count is an integer expression; cut to the counter width on purpose
	wire [31:0] offset_last = `OFFSET_PERIOD_CYC - 1;
	wire        offset_tick = offset_cnt_ff == offset_last[16:0];
	reg  [31:0] nxt_prdata;
	reg         hit;

	// --------------------------------------------------------------
	// apb read mux
	// --------------------------------------------------------------
	always @* begin
		nxt_prdata = 32'h0000_0000;
		hit = 1'b1;
		case (paddr)
			`ADDR_OPT_A:     nxt_prdata = {24'h0, opt_a_ff}; // RULE21
			`ADDR_OPT_B:     nxt_prdata = {24'h0, opt_b_ff};
			`ADDR_OPT_C:     nxt_prdata = {24'h0, opt_c_ff};
			`ADDR_DIVIDER:   nxt_prdata = {16'h0, divider_ff};
			`ADDR_CELLS:     nxt_prdata = {24'h0, cells_ff};
			`ADDR_CAL:       nxt_prdata = {15'h0, cal_target_ff, cal_busy_ff};
			`ADDR_VOLT_RAW:  nxt_prdata = {16'h0, volt_raw};
			`ADDR_VOLT:      nxt_prdata = {16'h0, stack_voltage_mv};
			`ADDR_SENSE_RAW: nxt_prdata = {16'h0, sense_raw};
			`ADDR_SENSE:     nxt_prdata = {16'h0, sense_resistor_voltage};
			`ADDR_OFFSET:    nxt_prdata = {16'h0, offset_ff};
			`ADDR_STATUS:    nxt_prdata = {29'h0, relaxing, discharging, charging};
			default:         hit = 1'b0;
		endcase
	end

	// no wait state: pready rises in the first access cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			if (setup) begin
				prdata  <= pwrite ? 32'h0000_0000 : nxt_prdata;
				pslverr <= ~hit;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

	// --------------------------------------------------------------
	// configuration registers and calibration
	// --------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opt_a_ff      <= `RST_OPT_A; // RULE20
			opt_b_ff      <= `RST_OPT_B; // RULE1 RULE2 RULE5 RULE6
			opt_c_ff      <= `RST_OPT_C;
			divider_ff    <= `RST_DIVIDER; // RULE16
			cells_ff      <= `RST_CELLS; // RULE16
			cal_busy_ff   <= 1'b0;
			cal_target_ff <= 16'h0000;
			offset_ff     <= 16'h0000;
			offset_cnt_ff <= 17'h00000;
		end else begin
			offset_cnt_ff <= offset_tick ? 17'h00000 : offset_cnt_ff + 17'h00001;
			// periodic zero-current sample taken as new offset
			if (offset_tick)
				offset_ff <= sense_zero; // RULE19
			if (wr_en) begin
				case (paddr)
					`ADDR_OPT_A:   opt_a_ff   <= pwdata[7:0] & `OPT_A_MASK; // RULE21
					`ADDR_OPT_B:   opt_b_ff   <= pwdata[7:0] & `OPT_B_MASK; // RULE21
					`ADDR_OPT_C:   opt_c_ff   <= pwdata[7:0] & `OPT_C_MASK;
					`ADDR_DIVIDER: divider_ff <= pwdata[15:0];
					`ADDR_CELLS:   cells_ff   <= pwdata[7:0];
					`ADDR_CAL: begin
						if (pwdata[`CAL_START]) begin
							cal_busy_ff   <= 1'b1;
							cal_target_ff <= pwdata[31:16];
						end
						if (pwdata[`CAL_OFFSET])
							offset_ff <= sense_zero; // RULE19
					end
					default: ;
				endcase
			end else if (cal_busy_ff) begin
				// step factor until reported equals applied; a zero raw reading cannot converge
				if (volt_scaled == cal_target_ff || volt_raw == 16'h0000)
					cal_busy_ff <= 1'b0; // RULE18
				else if (volt_scaled < cal_target_ff && divider_ff != 16'hFFFF)
					divider_ff <= divider_ff + 16'h0001; // RULE18
				else if (volt_scaled > cal_target_ff && divider_ff != 16'h0000)
					divider_ff <= divider_ff - 16'h0001; // RULE18
				else
					cal_busy_ff <= 1'b0;
			end
		end
	end

	// --------------------------------------------------------------
	// decoded controls
	// --------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			charge_depth_end_update_en       <= 1'b0;
			voltage_consistency_check_en     <= 1'b0;
			temperature_banded_charge_report <= 1'b0;
			phosphate_relax_mode_en          <= 1'b0;
			depth_weighting_en               <= 1'b0;
			fast_convergence_en              <= 1'b0;
			health_display_en                <= 1'b0;
			charge_percent_no_rise           <= 1'b0;
			fast_filter_near_empty           <= 1'b0;
			sleep_fast_sampling_en           <= 1'b0;
			hold_zero_in_relax               <= 1'b0;
			relax_step_allow                 <= 1'b0;
			relax_filtering_allow            <= 1'b0;
			charge_smoothing_en              <= 1'b0;
			divider_source_select            <= 1'b0;
			internal_divider_on              <= 1'b0;
			stack_voltage_mv                 <= 16'h0000;
			sense_resistor_voltage           <= 16'h0000;
		end else begin
			charge_depth_end_update_en       <= opt_b_ff[`OPT_B_DEPTH_EOC] & charging; // RULE1
			voltage_consistency_check_en     <= opt_b_ff[`OPT_B_VCONS]; // RULE2
			temperature_banded_charge_report <= opt_b_ff[`OPT_B_BANDED]; // RULE3
			phosphate_relax_mode_en          <= opt_b_ff[`OPT_B_PHOS]; // RULE4
			depth_weighting_en               <= opt_b_ff[`OPT_B_DWT] & (chem_id[11:8] == `CHEM_400_HI); // RULE5
			fast_convergence_en              <= opt_b_ff[`OPT_B_FCONV]; // RULE6
			health_display_en                <= opt_c_ff[`OPT_C_HEALTH]; // RULE7
			charge_percent_no_rise           <= opt_c_ff[`OPT_C_NORISE] & discharging; // RULE8
			fast_filter_near_empty           <= opt_c_ff[`OPT_C_FFEDV]; // RULE10
			sleep_fast_sampling_en           <= opt_c_ff[`OPT_C_SLEEP]; // RULE11
			hold_zero_in_relax               <= opt_c_ff[`OPT_C_LOCK0] & relaxing; // RULE12
			relax_step_allow                 <= opt_c_ff[`OPT_C_RSTEP] & opt_c_ff[`OPT_C_SMOOTH] & relaxing; // RULE13
			relax_filtering_allow            <= opt_c_ff[`OPT_C_RSMOOTH] & opt_c_ff[`OPT_C_SMOOTH] & relaxing; // RULE14
			charge_smoothing_en              <= opt_c_ff[`OPT_C_SMOOTH]; // RULE14
			divider_source_select            <= opt_a_ff[`OPT_A_VSEL]; // RULE15
			internal_divider_on              <= ~opt_a_ff[`OPT_A_VSEL]; // RULE15
			stack_voltage_mv                 <= volt_scaled; // RULE17
			sense_resistor_voltage           <= sense_raw - offset_ff; // RULE19
		end
	end

endmodule

// *** design/gauge_pack_defines.vh ***
// How it works
// RULE1 - option B bit 7 enables charge-end depth update, only while charging; resets set
// RULE2 - option B bit 5 enables voltage consistency check; resets set
// RULE3 - option B bit 3 set: banded charge report; clear: mid-band values reported
// RULE4 - option B bit 2 enables phosphate relax handling
// RULE5 - option B bit 1 enables depth weighting, only for 400-series chemistry; resets set
// RULE6 - option B bit 0 enables fast convergence; resets set
// RULE7 - option C bit 7 shows health instead of remaining charge
// RULE8 - option C bit 6 stops charge percent rising while discharging
// RULE9 - software should clear the no-rise bit whenever smoothing is set
// RULE10 - option C bit 5 enables fast filter near end-of-discharge voltage
// RULE11 - option C bit 4 enables faster sampling in sleep
// RULE12 - option C bit 3 keeps charge at zero through relaxation after empty
// RULE13 - option C bit 2 lets percent step in relax, only with smoothing
// RULE14 - option C bit 0 enables smoothing; bit 1 extends it into relax
// RULE15 - divider select clear uses internal 5:1 divider, set uses external
// RULE16 - divider factor resets to 5000, series cell count resets to one
// RULE17 - stack voltage up to 65535 mV with about 900 mV at input
// RULE18 - calibration adjusts divider factor so reported equals applied voltage
// RULE19 - sense offset measured periodically and subtracted from every sense sample
// RULE20 - divider select is bit 3 of option A high byte, resets zero
// RULE21 - reserved bits read zero and ignore writes
`ifndef GAUGE_PACK_DEFINES_VH
`define GAUGE_PACK_DEFINES_VH

// --------------------------------------------------------------
// register byte addresses
// --------------------------------------------------------------
`define ADDR_OPT_A      12'h000
`define ADDR_OPT_B      12'h004
`define ADDR_OPT_C      12'h008
`define ADDR_DIVIDER    12'h00C
`define ADDR_CELLS      12'h010
`define ADDR_CAL        12'h014
`define ADDR_VOLT_RAW   12'h018
`define ADDR_VOLT       12'h01C
`define ADDR_SENSE_RAW  12'h020
`define ADDR_SENSE      12'h024
`define ADDR_OFFSET     12'h028
`define ADDR_STATUS     12'h02C

// --------------------------------------------------------------
// field positions and masks
// --------------------------------------------------------------
`define OPT_A_MASK      8'h08
`define OPT_A_VSEL      3
`define OPT_B_MASK      8'hAF
`define OPT_B_DEPTH_EOC 7
`define OPT_B_VCONS     5
`define OPT_B_BANDED    3
`define OPT_B_PHOS      2
`define OPT_B_DWT       1
`define OPT_B_FCONV     0
`define OPT_C_MASK      8'hFF
`define OPT_C_HEALTH    7
`define OPT_C_NORISE    6
`define OPT_C_FFEDV     5
`define OPT_C_SLEEP     4
`define OPT_C_LOCK0     3
`define OPT_C_RSTEP     2
`define OPT_C_RSMOOTH   1
`define OPT_C_SMOOTH    0
`define CAL_START       0
`define CAL_OFFSET      1

// --------------------------------------------------------------
// reset values and the 400-series chemistry code
// --------------------------------------------------------------
`define RST_OPT_A       8'h00
`define RST_OPT_B       8'hA3
`define RST_OPT_C       8'h00
`define RST_DIVIDER     16'h1388
`define RST_CELLS       8'h01
`define CHEM_400_HI     4'h4

// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define CLK_MHZ         25
`define OFFSET_PERIOD_US 100
`define OFFSET_PERIOD_CYC (`OFFSET_PERIOD_US * `CLK_MHZ)

`endif

// *** test/gauge_pack_monitor.sv ***
`timescale 1ns/1ps
module gauge_pack_monitor (
	// apb
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	// engine state
	input wire        charging,
	input wire        discharging,
	input wire        relaxing,
	input wire [11:0] chem_id,
	// controls
	input wire        charge_depth_end_update_en,
	input wire        depth_weighting_en,
	input wire        charge_percent_no_rise,
	input wire        hold_zero_in_relax,
	input wire        relax_step_allow,
	input wire        relax_filtering_allow,
	input wire        charge_smoothing_en,
	input wire        divider_source_select,
	input wire        internal_divider_on
);
	// ------------------------------------------------
	// gating and bus checks
	// ------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	depth_end_a: assert property (charge_depth_end_update_en |-> $past(charging))
		else $error("depth update outside charging");
	weight_chem_a: assert property (depth_weighting_en |-> $past(chem_id[11:8]) == 4'h4)
		else $error("depth weighting without 400 series");
	no_rise_a: assert property (charge_percent_no_rise |-> $past(discharging))
		else $error("no-rise outside discharge");
	hold_zero_a: assert property (hold_zero_in_relax |-> $past(relaxing))
		else $error("zero hold outside relax");
	relax_step_a: assert property (relax_step_allow |-> charge_smoothing_en && $past(relaxing))
		else $error("relax step without smoothing");
	relax_filter_a: assert property (relax_filtering_allow |-> charge_smoothing_en && $past(relaxing))
		else $error("relax smoothing without smoothing");
	// the first edge after release still shows reset values
	divider_pair_a: assert property ($past(presetn) |-> divider_source_select != internal_divider_on)
		else $error("divider select and internal enable agree");
	unmapped_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h00000000)
		else $error("unmapped read returned data");
	pready_one_a: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready not a one-cycle answer");
endmodule
bind gauge_pack_config gauge_pack_monitor mon (.*);

// *** test/tb.sv ***
`timescale 1ns/1ps
`include "gauge_pack_defines.vh"
module tb;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        charging = 0, discharging = 0, relaxing = 0, err;
	logic [11:0] paddr = 12'h000, chem_id = 12'h000;
	logic [31:0] pwdata = 32'h00000000, rd;
	logic [15:0] volt_raw = 16'h0000, sense_raw = 16'h0000, sense_zero = 16'h0000;
	logic [7:0]  cv [10] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'h05, 8'h03};
	wire  [31:0] prdata;
	wire         pready, pslverr, charge_depth_end_update_en, voltage_consistency_check_en;
	wire         temperature_banded_charge_report, phosphate_relax_mode_en, depth_weighting_en;
	wire         fast_convergence_en, health_display_en, charge_percent_no_rise, fast_filter_near_empty;
	wire         sleep_fast_sampling_en, hold_zero_in_relax, relax_step_allow, relax_filtering_allow;
	wire         charge_smoothing_en, divider_source_select, internal_divider_on;
	wire  [15:0] stack_voltage_mv, sense_resistor_voltage;
	wire  [7:0]  obs_b = {charge_depth_end_update_en, 1'b0, voltage_consistency_check_en, 1'b0,
		temperature_banded_charge_report, phosphate_relax_mode_en, depth_weighting_en, fast_convergence_en};
	wire  [7:0]  obs_c = {health_display_en, charge_percent_no_rise, fast_filter_near_empty,
		sleep_fast_sampling_en, hold_zero_in_relax, relax_step_allow, relax_filtering_allow, charge_smoothing_en};
	integer      miscompares = 0, num_checks = 0, cyc = 0, i;

	gauge_pack_config uut (.*);

	always #20 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			miscompares = miscompares + 1;
			test_done;
		end
	end
	// ------------------------------------------------
	// access tasks
	// ------------------------------------------------
	task test_done;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks = num_checks + 1;
		if (g !== e) begin
			miscompares = miscompares + 1;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// the only wait on pready; the cycle timeout ends a hang
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h00000000);
		chk(nm, e, rd);
	endtask
	task tick(input integer n);
		repeat (n) @(posedge pclk);
	endtask
	initial begin
		tick(10);
		presetn <= 1'b1;
		rdc("opt_a", `ADDR_OPT_A, 32'h00000000);
		rdc("opt_b", `ADDR_OPT_B, 32'h000000A3);
		rdc("divider", `ADDR_DIVIDER, 32'h00001388);
		rdc("cells", `ADDR_CELLS, 32'h00000001);
		chk("defaults", 32'h7, {fast_convergence_en, voltage_consistency_check_en, internal_divider_on});
		$display("reset test done");
		charging <= 1'b1;
		chem_id <= 12'h412;
		for (i = 0; i < 8; i++) begin
			apb(1'b1, `ADDR_OPT_B, 32'h1 << i);
			tick(3);
			chk("opt_b_out", (32'h1 << i) & 32'hAF, obs_b);
			rdc("opt_b_rd", `ADDR_OPT_B, (32'h1 << i) & 32'hAF);
		end
		charging <= 1'b0;
		chem_id <= 12'h3FF;
		apb(1'b1, `ADDR_OPT_B, 32'hFFFFFFFF);
		tick(3);
		chk("opt_b_gated", 32'h2D, obs_b);
		$display("option b test done");
		discharging <= 1'b1;
		relaxing <= 1'b1;
		for (i = 0; i < 10; i++) begin
			apb(1'b1, `ADDR_OPT_C, cv[i]);
			tick(3);
			chk("opt_c_out", cv[i] & {5'h1F, cv[i][0], cv[i][0], 1'b1}, obs_c);
			rdc("opt_c_rd", `ADDR_OPT_C, cv[i]);
		end
		discharging <= 1'b0;
		relaxing <= 1'b0;
		apb(1'b1, `ADDR_OPT_C, 32'h000000BF);
		tick(3);
		chk("opt_c_gated", 32'hB1, obs_c);
		apb(1'b1, `ADDR_OPT_C, 32'h00000040);
		tick(3);
		chk("no_rise_gated", 32'h00, obs_c);
		apb(1'b1, `ADDR_OPT_A, 32'hFFFFFFFF);
		tick(3);
		rdc("opt_a_rd", `ADDR_OPT_A, 32'h00000008);
		chk("divider_ext", 32'h2, {divider_source_select, internal_divider_on});
		apb(1'b1, `ADDR_OPT_A, 32'h00000000);
		tick(3);
		chk("divider_int", 32'h1, {divider_source_select, internal_divider_on});
		$display("option test done");
		volt_raw <= 16'h000D;
		tick(3);
		chk("stack", 32'hFDE8, stack_voltage_mv);
		volt_raw <= 16'h000E;
		tick(3);
		chk("stack_sat", 32'hFFFF, stack_voltage_mv);
		volt_raw <= 16'h0064;
		apb(1'b1, `ADDR_DIVIDER, 32'h0000000A);
		apb(1'b1, `ADDR_CAL, {16'h05DC, 16'h0001});
		// a write answers with zero data, so force at least one busy poll
		rd = 32'h00000001;
		for (i = 0; i < 20 && rd[0] !== 1'b0; i++)
			apb(1'b0, `ADDR_CAL, 32'h00000000);
		chk("cal_busy", 32'h0, rd[0]);
		rdc("cal_div", `ADDR_DIVIDER, 32'h0000000F);
		chk("cal_volt", 32'h05DC, stack_voltage_mv);
		sense_zero <= 16'h0005;
		sense_raw <= 16'h0064;
		apb(1'b1, `ADDR_CAL, 32'h00000002);
		tick(3);
		chk("sense", 32'h005F, sense_resistor_voltage);
		rdc("offset", `ADDR_OFFSET, 32'h00000005);
		sense_zero <= 16'h0007;
		sense_raw <= 16'h0003;
		tick(2600);
		chk("sense_periodic", 32'hFFFC, sense_resistor_voltage);
		apb(1'b1, 12'h030, 32'hFFFFFFFF);
		chk("unmapped_wr", 32'h1, err);
		apb(1'b0, 12'h030, 32'h00000000);
		chk("unmapped_err", 32'h1, err);
		chk("unmapped_data", 32'h0, rd);
		$display("scaling test done");
		test_done;
	end
endmodule
